/* hdl/silence_pin_cfg.svh */
`ifndef SILENCE_PIN_CFG_SVH
`define SILENCE_PIN_CFG_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_STATUS_SEL 6'h02
`define IDX_PIN_DIR 6'h03
`define IDX_FUNC_A 6'h0c
`define IDX_FUNC_B 6'h0d
`define IDX_CTRL 6'h10
`define IDX_STATUS 6'h11

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define DIR_OUT_BIT 3
`define RST_PIN_DIR 4'h0
`define RST_FUNC_A 4'h0
`define RST_FUNC_B 4'h0
`define RST_CTRL 4'h0
`define RST_STATUS_SEL 4'h0
`define SEL_FIRST_PIN 4'h0
`define SEL_SHARED_PIN 4'h1
`define SEL_LEFT_SIL 4'h2
`define SEL_RIGHT_SIL 4'h3
`define PIN_MODE_FUNC 2'h1
`define PIN_MODE_LOW 2'h2
`define PIN_MODE_HIGH 2'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define AUDIO_W 16
`define SIL_CNT_W 24
`define CLK_HZ 64'd50000000
`define SILENCE_TIME_MS 64'd270
`define SILENCE_CYCLES \
  24'((`SILENCE_TIME_MS * `CLK_HZ + 64'd999) / 64'd1000)

`endif

/* hdl/silence_pin_pkg.sv */
package silence_pin_pkg;

  typedef struct packed {
    logic split_mode;
    logic [1:0] third_mode;
    logic first_ext;
  } func_a_t;

  typedef struct packed {
    logic [1:0] fifth_mode;
    logic [1:0] fourth_mode;
  } func_b_t;

  typedef struct packed {
    logic rsvd;
    logic audio_off;
    logic cdrom_mode;
    logic mute;
  } ctrl_t;

  typedef struct packed {
    logic right_sil;
    logic left_sil;
    logic shared_lvl;
    logic first_lvl;
  } status_t;

  function automatic logic is_silent(input logic [15:0] w);
    is_silent = (w == 16'h0000) || (&w);
  endfunction

endpackage

/* hdl/silence_timer.sv */
`timescale 1ns/10ps
`include "silence_pin_cfg.svh"

module silence_timer
#(
  parameter logic [`SIL_CNT_W-1:0] SILENCE_CYCLES = `SILENCE_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clear,
  output logic done
);

  logic [`SIL_CNT_W-1:0] cnt_ff;
  logic [`SIL_CNT_W-1:0] nxt_cnt;

  // saturates so a long silence never wraps back to not-done
  assign done = (cnt_ff == SILENCE_CYCLES);
  assign nxt_cnt = clear ? '0 : (done ? cnt_ff : cnt_ff + 1'b1);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

endmodule

/* hdl/silence_detect_and_pin_mux.sv */
// Local design decision: register access over APB.
`timescale 1ns/10ps
`include "silence_pin_cfg.svh"

// What this block does
// - silence is an all-zero or all-one word
// - silence output low after 270 ms silence
// - mute or cd-rom mode forces silence output and third pin (right silence) low
// - combined mode needs both channels silent
// - split mode: left on main, right on third
// - audio off disables detection, outputs stay active
// - audio off may leave fifth pin undefined
// - direction bit 3: 0 input (reset), 1 open-drain
// - direction and function fields stay independent
// - first pin external or internal off-track
// - shared pin input level readable via status
// - third pin right silence, low or high
// - fourth pin motor, subcode, low or high
// - fifth pin de-emphasis, low or high
// - four-line motor uses two extra pins
module silence_detect_and_pin_mux
  import silence_pin_pkg::*;
#(
  parameter logic [`SIL_CNT_W-1:0] SILENCE_CYCLES = `SILENCE_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic audio_valid,
  input wire logic [`AUDIO_W-1:0] audio_left,
  input wire logic [`AUDIO_W-1:0] audio_right,
  input wire logic subcode_qw,
  input wire logic deemph_flag,
  input wire logic pwm4_sel,
  input wire logic motor_bridge_a,
  input wire logic motor_bridge_b,
  input wire logic int_offtrack,
  input wire logic multi_pin_first_in,
  input wire logic shared_multi_pin_i,
  output logic shared_multi_pin_o,
  output logic shared_multi_pin_oe,
  output logic silence_out_n,
  output logic multi_pin_fourth_out,
  output logic multi_pin_fifth_out,
  output logic offtrack_used,
  output logic status_bit_out
);

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [3:0] pin_dir_ff;
  func_a_t func_a_ff;
  func_b_t func_b_ff;
  ctrl_t ctrl_ff;
  logic [3:0] status_sel_ff;
  logic [31:0] prdata_ff;
  status_t status;

  wire [5:0] reg_idx = paddr[7:2];
  wire aligned = (paddr[1:0] == 2'b00);
  wire hit_sel = aligned && (reg_idx == `IDX_STATUS_SEL);
  wire hit_dir = aligned && (reg_idx == `IDX_PIN_DIR);
  wire hit_fa = aligned && (reg_idx == `IDX_FUNC_A);
  wire hit_fb = aligned && (reg_idx == `IDX_FUNC_B);
  wire hit_ctrl = aligned && (reg_idx == `IDX_CTRL);
  wire hit_stat = aligned && (reg_idx == `IDX_STATUS);
  wire hit_any = hit_sel | hit_dir | hit_fa | hit_fb | hit_ctrl | hit_stat;
  wire setup_ph = psel && !penable;
  wire wr_en = psel && penable && pwrite;

  // zero wait states; read data is captured during setup
  assign pready = psel && penable;
  assign pslverr = psel && penable && !hit_any;

  // function registers are write-only and read back as zero
  wire [31:0] rd_val = hit_stat ? {28'h0000000, status} :
                       hit_ctrl ? {28'h0000000, ctrl_t'(ctrl_ff)} :
                       hit_sel ? {28'h0000000, status_sel_ff} :
                       32'h00000000;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pin_dir_ff <= `RST_PIN_DIR;
      func_a_ff <= `RST_FUNC_A;
      func_b_ff <= `RST_FUNC_B;
      ctrl_ff <= `RST_CTRL;
      status_sel_ff <= `RST_STATUS_SEL;
    end
    else if (wr_en)
    begin
      // each field has its own register, so order of writes is free
      if (hit_dir)
        pin_dir_ff <= pwdata[3:0];
      if (hit_fa)
        func_a_ff <= pwdata[3:0];
      if (hit_fb)
        func_b_ff <= pwdata[3:0];
      if (hit_ctrl)
        ctrl_ff <= pwdata[3:0];
      if (hit_sel)
        status_sel_ff <= pwdata[3:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      prdata_ff <= 32'h00000000;
    else if (setup_ph)
      prdata_ff <= pwrite ? 32'h00000000 : rd_val;
  end

  assign prdata = prdata_ff;

  // ----------------------------------------
  // pin input synchronisers
  // ----------------------------------------
  logic first_meta_ff;
  logic first_sync_ff;
  logic shared_meta_ff;
  logic shared_sync_ff;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      first_meta_ff <= 1'b0;
      first_sync_ff <= 1'b0;
      shared_meta_ff <= 1'b1;
      shared_sync_ff <= 1'b1;
    end
    else
    begin
      first_meta_ff <= multi_pin_first_in;
      first_sync_ff <= first_meta_ff;
      shared_meta_ff <= shared_multi_pin_i;
      shared_sync_ff <= shared_meta_ff;
    end
  end

  // ----------------------------------------
  // silence detection
  // ----------------------------------------
  logic left_sil_ff;
  logic right_sil_ff;
  logic left_done;
  logic right_done;

  wire audio_off = ctrl_ff.audio_off;
  wire forced = ctrl_ff.mute || ctrl_ff.cdrom_mode;
  wire left_word_sil = is_silent(audio_left);
  wire right_word_sil = is_silent(audio_right);

  // a channel stays silent until a non-silent word arrives or audio off is set
  always_ff @(posedge clk_sys)
  begin
    if (rst || audio_off)
    begin
      left_sil_ff <= 1'b0;
      right_sil_ff <= 1'b0;
    end
    else if (audio_valid)
    begin
      left_sil_ff <= left_word_sil;
      right_sil_ff <= right_word_sil;
    end
  end

  silence_timer #(.SILENCE_CYCLES(SILENCE_CYCLES)) u_left_timer
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(!left_sil_ff),
    .done(left_done)
  );

  silence_timer #(.SILENCE_CYCLES(SILENCE_CYCLES)) u_right_timer
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(!right_sil_ff),
    .done(right_done)
  );

  wire main_sil = func_a_ff.split_mode ? left_done :
                  (left_done && right_done);
  wire nxt_silence_n = !(forced || main_sil);
  wire right_kill_n = !(forced || right_done);

  // ----------------------------------------
  // multi-purpose pins
  // ----------------------------------------
  logic silence_n_ff;
  logic third_val_ff;
  logic fourth_ff;
  logic fifth_ff;
  logic offtrack_ff;
  logic status_bit_ff;

  wire dir_out = pin_dir_ff[`DIR_OUT_BIT];
  // third pin value is kept even while the pin is an input
  wire nxt_third = func_a_ff.third_mode[0] ? func_a_ff.third_mode[1] :
                   right_kill_n;
  wire motor_mode = (func_b_ff == 4'h0);
  wire nxt_fourth = motor_mode ? (pwm4_sel && motor_bridge_a) :
    (func_b_ff.fourth_mode == `PIN_MODE_FUNC) ? subcode_qw :
    (func_b_ff.fourth_mode == `PIN_MODE_HIGH);
  // with audio off the de-emphasis flag is passed through as is
  wire nxt_fifth = motor_mode ? (pwm4_sel && motor_bridge_b) :
    (func_b_ff.fifth_mode == `PIN_MODE_FUNC) ? deemph_flag :
    (func_b_ff.fifth_mode == `PIN_MODE_HIGH);
  wire nxt_offtrack = func_a_ff.first_ext ? first_sync_ff :
                      int_offtrack;

  // one driver for the whole struct, not one per field
  assign status = '{
    right_sil: right_done,
    left_sil: left_done,
    shared_lvl: shared_sync_ff,
    first_lvl: first_sync_ff
  };

  wire nxt_status_bit =
    (status_sel_ff == `SEL_FIRST_PIN) ? status.first_lvl :
    (status_sel_ff == `SEL_SHARED_PIN) ? status.shared_lvl :
    (status_sel_ff == `SEL_LEFT_SIL) ? status.left_sil :
    (status_sel_ff == `SEL_RIGHT_SIL) ? status.right_sil :
    1'b0;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      silence_n_ff <= 1'b1;
      third_val_ff <= 1'b1;
      fourth_ff <= 1'b0;
      fifth_ff <= 1'b0;
      offtrack_ff <= 1'b0;
      status_bit_ff <= 1'b0;
    end
    else
    begin
      silence_n_ff <= nxt_silence_n;
      third_val_ff <= nxt_third;
      fourth_ff <= nxt_fourth;
      fifth_ff <= nxt_fifth;
      offtrack_ff <= nxt_offtrack;
      status_bit_ff <= nxt_status_bit;
    end
  end

  // open drain: only a low is driven, a high is left to the pull-up
  assign shared_multi_pin_o = 1'b0;
  assign shared_multi_pin_oe = dir_out && !third_val_ff;
  assign silence_out_n = silence_n_ff;
  assign multi_pin_fourth_out = fourth_ff;
  assign multi_pin_fifth_out = fifth_ff;
  assign offtrack_used = offtrack_ff;
  assign status_bit_out = status_bit_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic [`SIL_CNT_W-1:0] run_cnt_ff;

  always_ff @(posedge clk_sys)
  begin
    if (rst || !left_sil_ff)
      run_cnt_ff <= '0;
    else if (run_cnt_ff != SILENCE_CYCLES)
      run_cnt_ff <= run_cnt_ff + 1'b1;
  end

  sequence nonsilent_left;
    audio_valid && !left_word_sil && !audio_off;
  endsequence

  sequence left_released;
    ##2 !left_done;
  endsequence

  a_word_detect: assert property (
    audio_valid && left_word_sil && !audio_off |=> left_sil_ff)
    else $error("silent word not recognised");

  a_silence_wait: assert property (
    $rose(left_done) |-> run_cnt_ff >= SILENCE_CYCLES)
    else $error("silence flagged too early");

  a_force_low: assert property (
    forced |=> !silence_out_n && (!dir_out || shared_multi_pin_oe ||
                                  func_a_ff.third_mode[0]))
    else $error("forced silence not driven low");

  a_combined_mode: assert property (
    !func_a_ff.split_mode && !forced && !(left_done && right_done)
    |=> silence_out_n)
    else $error("combined mode went low with one channel");

  a_split_mode: assert property (
    func_a_ff.split_mode && !forced |=> silence_out_n == !$past(left_done))
    else $error("split mode left silence mismatch");

  a_audio_off: assert property (
    audio_off [*3] |-> !left_done && !right_done)
    else $error("detection active with audio off");

  a_restart_count: assert property (
    nonsilent_left |-> left_released)
    else $error("non-silent word did not restart count");

  a_dir_input: assert property (
    !dir_out |-> !shared_multi_pin_oe)
    else $error("shared pin driven while input");

  a_third_forced: assert property (
    func_a_ff.third_mode == 2'b01 && $past(func_a_ff.third_mode) == 2'b01
    && dir_out |-> shared_multi_pin_oe)
    else $error("third pin not forced low");

  a_motor_route: assert property (
    motor_mode |=> multi_pin_fourth_out == $past(pwm4_sel && motor_bridge_a)
    && multi_pin_fifth_out == $past(pwm4_sel && motor_bridge_b))
    else $error("motor bridge signals not routed");

  a_fifth_deemph: assert property (
    func_b_ff.fifth_mode == `PIN_MODE_FUNC && !motor_mode
    |=> multi_pin_fifth_out == $past(deemph_flag))
    else $error("fifth pin not de-emphasis");

  a_status_shared: assert property (
    status_sel_ff == `SEL_SHARED_PIN |=> status_bit_out ==
    $past(shared_multi_pin_i, 3))
    else $error("shared pin level not on status bit");

endmodule

/* verification/ext_pins.sv */
`timescale 1ns/10ps
// ----------------------------------------
// board side of the shared open-drain pin
// ----------------------------------------
module ext_pins
(
  input wire logic pin_oe,
  input wire logic pull_low,
  output logic pin_level
);
  // pull-up: a released wire reads high, never the last driven value
  assign pin_level = !(pin_oe || pull_low);
endmodule

/* verification/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import silence_pin_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  // short silence time keeps the run brief
  localparam logic [23:0] SIL = 24'h000014;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic audio_valid, subcode_qw, deemph_flag, pwm4_sel;
  logic motor_bridge_a, motor_bridge_b, int_offtrack, multi_pin_first_in;
  logic [15:0] audio_left, audio_right;
  logic shared_lvl, shared_o, shared_oe, ext_low, silence_out_n;
  logic fourth, fifth, offtrack_used, status_bit_out;
  int fails, comparisons;

  silence_detect_and_pin_mux #(.SILENCE_CYCLES(SIL)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .audio_valid(audio_valid),
    .audio_left(audio_left), .audio_right(audio_right),
    .subcode_qw(subcode_qw), .deemph_flag(deemph_flag),
    .pwm4_sel(pwm4_sel), .motor_bridge_a(motor_bridge_a),
    .motor_bridge_b(motor_bridge_b), .int_offtrack(int_offtrack),
    .multi_pin_first_in(multi_pin_first_in),
    .shared_multi_pin_i(shared_lvl), .shared_multi_pin_o(shared_o),
    .shared_multi_pin_oe(shared_oe), .silence_out_n(silence_out_n),
    .multi_pin_fourth_out(fourth), .multi_pin_fifth_out(fifth),
    .offtrack_used(offtrack_used), .status_bit_out(status_bit_out));

  ext_pins i_ext (.pin_oe(shared_oe), .pull_low(ext_low),
    .pin_level(shared_lvl));

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task close_out();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // one apb transfer; read data and error land in rd and err
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    @(posedge clk_sys);
    while (pready !== 1'b1 && i < 20)
    begin
      @(posedge clk_sys);
      i++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, 32'(pready));
    if (i >= 20)
      close_out();
  endtask

  task wait_sil(input logic e, input int n);
    int i;
    i = 0;
    while (silence_out_n !== e && i < n)
    begin
      cyc(1);
      i++;
    end
    chk("silence_out_n", 32'(e), 32'(silence_out_n));
    if (i >= n)
      close_out();
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {subcode_qw, deemph_flag, pwm4_sel, motor_bridge_a} = '0;
    {motor_bridge_b, int_offtrack, multi_pin_first_in, ext_low} = '0;
    audio_valid = 1'b1;
    audio_left = 16'h1234;
    audio_right = 16'h4321;
    fails = 0;
    comparisons = 0;
    rst = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(1);
    chk("oe", 32'h0, 32'(shared_oe));
    chk("kill", 32'h1, 32'(silence_out_n));
    apb(1'b1, 8'h40, 32'h3);
    apb(1'b0, 8'h40, 32'h0);
    chk("ctrl", 32'h3, rd);
    apb(1'b1, 8'h40, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk("dir read", 32'h0, rd);
    apb(1'b0, 8'h50, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped rd", 32'h0, rd);
    apb(1'b0, 8'h41, 32'h0);
    chk("unaligned err", 32'h1, 32'(err));
    $display("test registers done");

    @(posedge clk_sys);
    audio_left <= 16'h0000;
    audio_right <= 16'hffff;
    cyc(int'(SIL));
    chk("kill early", 32'h1, 32'(silence_out_n));
    wait_sil(1'b0, 30);
    @(posedge clk_sys);
    audio_right <= 16'h1234;
    wait_sil(1'b1, 8);
    cyc(int'(SIL) + 10);
    chk("kill one side", 32'h1, 32'(silence_out_n));
    for (int c = 1; c < 3; c++)
    begin
      apb(1'b1, 8'h40, 32'(c));
      wait_sil(1'b0, 8);
      apb(1'b1, 8'h40, 32'h0);
      wait_sil(1'b1, 8);
    end
    $display("test silence done");

    apb(1'b1, 8'h0c, 32'h8);
    apb(1'b1, 8'h30, 32'h8);
    @(posedge clk_sys);
    audio_left <= 16'h0101;
    audio_right <= 16'hffff;
    cyc(int'(SIL) + 10);
    chk("kill split", 32'h1, 32'(silence_out_n));
    chk("third low", 32'h0, 32'(shared_lvl));
    @(posedge clk_sys);
    audio_left <= 16'h0000;
    wait_sil(1'b0, 30);
    @(posedge clk_sys);
    audio_left <= 16'h0101;
    audio_right <= 16'h0001;
    wait_sil(1'b1, 8);
    cyc(4);
    chk("third released", 32'h0, 32'(shared_oe));
    $display("test split done");

    apb(1'b1, 8'h0c, 32'h0);
    apb(1'b1, 8'h30, 32'h2);
    @(posedge clk_sys);
    ext_low <= 1'b1;
    apb(1'b1, 8'h08, 32'h1);
    cyc(5);
    chk("oe input", 32'h0, 32'(shared_oe));
    chk("status pin", 32'h0, 32'(status_bit_out));
    apb(1'b0, 8'h44, 32'h0);
    chk("status reg", 32'h0, 32'(rd[1]));
    @(posedge clk_sys);
    ext_low <= 1'b0;
    cyc(5);
    chk("status pin", 32'h1, 32'(status_bit_out));
    apb(1'b1, 8'h0c, 32'h8);
    cyc(4);
    chk("force low", 32'h0, 32'(shared_lvl));
    apb(1'b1, 8'h30, 32'h6);
    cyc(4);
    chk("force high", 32'h1, 32'(shared_lvl));
    chk("o", 32'h0, 32'(shared_o));
    $display("test shared pin done");

    for (int m = 1; m < 4; m++)
      for (int s = 0; s < 2; s++)
      begin
        apb(1'b1, 8'h34, 32'((m << 2) | m));
        @(posedge clk_sys);
        subcode_qw <= 1'(s);
        deemph_flag <= !1'(s);
        cyc(4);
        chk("fourth", (m == 1) ? 32'(s) : 32'(m == 3), 32'(fourth));
        chk("fifth", (m == 1) ? 32'(s == 0) : 32'(m == 3), 32'(fifth));
      end
    apb(1'b1, 8'h34, 32'h0);
    for (int b = 0; b < 2; b++)
    begin
      @(posedge clk_sys);
      pwm4_sel <= 1'b1;
      motor_bridge_a <= 1'(b);
      motor_bridge_b <= !1'(b);
      cyc(4);
      chk("motor a", 32'(b), 32'(fourth));
      chk("motor b", 32'(b == 0), 32'(fifth));
    end
    $display("test output pins done");

    apb(1'b1, 8'h30, 32'h1);
    @(posedge clk_sys);
    multi_pin_first_in <= 1'b1;
    cyc(5);
    chk("ext offtrack", 32'h1, 32'(offtrack_used));
    apb(1'b1, 8'h30, 32'h0);
    apb(1'b1, 8'h08, 32'h0);
    cyc(4);
    chk("int offtrack", 32'h0, 32'(offtrack_used));
    chk("first status", 32'h1, 32'(status_bit_out));
    @(posedge clk_sys);
    multi_pin_first_in <= 1'b0;
    int_offtrack <= 1'b1;
    cyc(5);
    chk("int offtrack", 32'h1, 32'(offtrack_used));
    chk("first status", 32'h0, 32'(status_bit_out));
    $display("test offtrack done");

    apb(1'b1, 8'h40, 32'h4);
    @(posedge clk_sys);
    audio_left <= 16'h0000;
    audio_right <= 16'h0000;
    cyc(int'(SIL) + 10);
    chk("kill audio off", 32'h1, 32'(silence_out_n));
    apb(1'b1, 8'h40, 32'h5);
    wait_sil(1'b0, 8);
    $display("test audio off done");
    close_out();
  end
endmodule
